// file: verilog/spp_fuse_prog.sv
// module: supply pulse decoder, bitfield registers and fuse control
//
// Function
// - a sequence is enable key, address group, then optional long fuse pulse
// - key is short high, one mid, short high, with no interruption
// - each mid-level pulse after the key advances the address by one
// - supply at zero clears all volatile bitfields
// - supply held at sustain keeps bitfields so more can be added
// - a blown fuse keeps its bitfield at one for good
// - never set bitfields read zero; only addressed fields get fused
// - trial value: one sequence whose pulse count is the whole value
// - permanent coding: one sequence per one-bit, address n weighs 2^(n-1)
// - lock bit at address 32 set and fused blocks all further coding
// - operate switch point is five data bits, one of 32 steps
// - mid pulses count, short high separates, long high blows fuses
`timescale 1ns/1ps
module spp_fuse_prog #(
    parameter int FUSE_CYC = spp_pkg::FUSE_PULSE_CYC,
    parameter int IDLE_CYC = spp_pkg::GROUP_IDLE_CYC
) (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    // supply level from the comparators
    input  wire logic [1:0]                    lvl_code,
    // fuse array
    input  wire logic [spp_pkg::NUM_FIELDS-1:0] fuse_sense,
    output logic                               fuse_blow,
    output logic [spp_pkg::ADDR_W-1:0]         fuse_addr,
    // calibration result
    output logic [spp_pkg::CAL_BITS-1:0]       operate_switch_point,
    output logic                               code_locked,
    // apb slave
    input  wire logic [spp_pkg::APB_AW-1:0]    paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic [31:0]                        prdata,
    output logic                               pready,
    output logic                               pslverr
);
    import spp_pkg::*;

    spp_sym_if sym ();

    spp_pulse_class #(
        .SYM_CYC  (SYMBOL_PULSE_CYC),
        .OFF_CYC  (INTERPULSE_OFF_CYC),
        .FUSE_CYC (FUSE_CYC),
        .IDLE_CYC (IDLE_CYC)
    ) u_class (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .lvl_code (lvl_code),
        .sym      (sym.src)
    );

    spp_state_t            state_ff;
    spp_state_t            nxt_state;
    logic [ADDR_W-1:0]     addr_cnt_ff;
    logic [NUM_FIELDS-1:0] vol_ff;
    logic [NUM_FIELDS-1:0] fields_ff;
    logic                  trial_ff;
    logic                  abort_ff;
    logic                  fuse_blow_ff;
    logic [ADDR_W-1:0]     fuse_addr_ff;
    logic [CAL_BITS-1:0]   op_point_ff;
    logic                  locked_ff;
    logic [31:0]           prdata_ff;
    logic                  pready_ff;
    logic                  pslverr_ff;

    // one-hot bitfield for an address; zero outside 1..32
    function automatic logic [NUM_FIELDS-1:0] fld_mask(
        input logic [ADDR_W-1:0] a
    );
        logic [NUM_FIELDS-1:0] m;
        m = '0;
        if (a != '0 && a <= ADDR_W'(LOCK_ADDR)) begin
            m = NUM_FIELDS'(1) << (a - ADDR_W'(1));
        end
        return m;
    endfunction

    function automatic logic reg_mapped(input logic [APB_AW-1:0] a);
        return a == REG_CTRL || a == REG_STATUS
            || a == REG_FIELDS || a == REG_ADDR;
    endfunction

    // lock comes from the effective fields, so a blown lock fuse
    // refuses coding again after every power cycle
    wire locked   = fields_ff[LOCK_ADDR-1];
    wire ev_zero  = sym.supply_zero;
    wire ev_bad   = sym.pulse_bad;
    wire ev_count = sym.pulse_count;
    wire ev_key   = sym.pulse_key;
    wire ev_fuse  = sym.pulse_fuse;
    wire ev_idle  = sym.group_idle;

    // an address group ends on a short key, a fuse pulse or a long rest
    wire commit = state_ff == ST_ADDR && !ev_zero && !ev_bad && !locked
                  && (ev_key || ev_fuse || ev_idle);
    wire [NUM_FIELDS-1:0] commit_mask = fld_mask(addr_cnt_ff);
    wire trial_ok = addr_cnt_ff <= ADDR_W'((1 << CAL_BITS) - 1);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (ev_key) begin
                    nxt_state = ST_KEY1;
                end
            end
            ST_KEY1: begin
                if (ev_count) begin
                    nxt_state = ST_KEY2;
                end else if (ev_key || ev_fuse || ev_idle) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_KEY2: begin
                if (ev_key) begin
                    nxt_state = ST_ADDR;
                end else if (ev_count || ev_fuse || ev_idle) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_ADDR: begin
                if (ev_fuse || ev_idle) begin
                    nxt_state = ST_IDLE;
                end else if (ev_key) begin
                    nxt_state = ST_KEY1;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        // noise, power loss or lock drop any sequence in progress
        if (ev_zero || ev_bad || locked) begin
            nxt_state = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // address counter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            addr_cnt_ff <= '0;
        end else if (state_ff == ST_KEY2 && nxt_state == ST_ADDR) begin
            addr_cnt_ff <= '0;
        end else if (state_ff == ST_ADDR && nxt_state == ST_ADDR
                     && ev_count && addr_cnt_ff != '1) begin
            addr_cnt_ff <= addr_cnt_ff + ADDR_W'(1);
        end
    end

    // volatile bitfields; a zero supply or reset clears them, and a trial commit whose count fits in CAL_BITS rewrites the low CAL_BITS fields
    always_ff @(posedge clk_sys) begin
        if (rst || ev_zero) begin
            vol_ff <= '0;
        end else if (commit) begin
            if (trial_ff) begin
                if (trial_ok) begin
                    vol_ff[CAL_BITS-1:0] <= addr_cnt_ff[CAL_BITS-1:0];
                end
            end else begin
                vol_ff <= vol_ff | commit_mask;
            end
        end
    end

    // blown fuses override the volatile copy; unset fields read zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fields_ff <= '0;
        end else begin
            fields_ff <= vol_ff | fuse_sense;
        end
    end

    // fuse strobe only for a field being set to one in bitfield mode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fuse_blow_ff <= 1'b0;
            fuse_addr_ff <= '0;
        end else if (commit && ev_fuse && !trial_ff
                     && commit_mask != '0) begin
            fuse_blow_ff <= 1'b1;
            fuse_addr_ff <= addr_cnt_ff;
        end else begin
            fuse_blow_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            op_point_ff <= '0;
            locked_ff   <= 1'b0;
        end else begin
            op_point_ff <= fields_ff[CAL_BITS-1:0];
            locked_ff   <= locked;
        end
    end

    // apb: one wait state, write and read data land with pready
    wire apb_setup = psel && penable && !pready_ff;
    wire apb_done  = psel && penable && pready_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trial_ff <= CTRL_TRIAL_RST;
        end else if (apb_done && pwrite && paddr == REG_CTRL) begin
            trial_ff <= pwdata[CTRL_TRIAL_BIT];
        end
    end

    // sticky abort: noise inside a sequence; set wins over clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            abort_ff <= 1'b0;
        end else if (ev_bad && state_ff != ST_IDLE) begin
            abort_ff <= 1'b1;
        end else if (apb_done && pwrite && paddr == REG_STATUS
                     && pwdata[STAT_ABORT_BIT]) begin
            abort_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= WORD_ZERO;
        end else begin
            pready_ff  <= apb_setup;
            pslverr_ff <= apb_setup && !reg_mapped(paddr);
            prdata_ff  <= WORD_ZERO;
            if (apb_setup && !pwrite) begin
                case (paddr)
                    REG_CTRL: begin
                        prdata_ff[CTRL_TRIAL_BIT] <= trial_ff;
                    end
                    REG_STATUS: begin
                        prdata_ff[STAT_ABORT_BIT] <= abort_ff;
                        prdata_ff[STAT_LOCK_BIT]  <= locked;
                        prdata_ff[STAT_STATE_LSB +: 2] <= state_ff;
                    end
                    REG_FIELDS: begin
                        prdata_ff <= fields_ff;
                    end
                    REG_ADDR: begin
                        prdata_ff[ADDR_W-1:0] <= addr_cnt_ff;
                    end
                    default: begin
                        prdata_ff <= WORD_ZERO;
                    end
                endcase
            end
        end
    end

    assign fuse_blow            = fuse_blow_ff;
    assign fuse_addr            = fuse_addr_ff;
    assign operate_switch_point = op_point_ff;
    assign code_locked          = locked_ff;
    assign prdata               = prdata_ff;
    assign pready               = pready_ff;
    assign pslverr              = pslverr_ff;

    a_key_entry: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == ST_ADDR && $past(state_ff) != ST_ADDR)
        |-> $past(state_ff) == ST_KEY2 && $past(ev_key))
        else $error("address mode entered without full key");

    a_addr_restart: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == ST_KEY2 && nxt_state == ST_ADDR) |=> addr_cnt_ff == '0)
        else $error("address counter not restarted after key");

    a_addr_step: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == ST_ADDR && nxt_state == ST_ADDR && ev_count
         && addr_cnt_ff < ADDR_W'(LOCK_ADDR))
        |=> addr_cnt_ff == $past(addr_cnt_ff) + ADDR_W'(1))
        else $error("address count did not advance on count pulse");

    a_zero_clear: assert property (@(posedge clk_sys) disable iff (rst)
        ev_zero |=> vol_ff == '0 ##1 fields_ff == $past(fuse_sense))
        else $error("zero supply did not clear volatile fields");

    a_fuse_keep: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> (fields_ff & $past(fuse_sense)) == $past(fuse_sense))
        else $error("blown fuse not reflected as one");

    a_lock_refuse: assert property (@(posedge clk_sys) disable iff (rst)
        locked |=> state_ff == ST_IDLE && !fuse_blow_ff)
        else $error("coding accepted while locked");

    a_fuse_strobe: assert property (@(posedge clk_sys) disable iff (rst)
        fuse_blow_ff |-> $past(state_ff) == ST_ADDR && $past(ev_fuse)
        && !$past(trial_ff) ##1 !fuse_blow_ff)
        else $error("fuse strobe without long pulse in address mode");

    a_trial_apply: assert property (@(posedge clk_sys) disable iff (rst)
        (commit && trial_ff && trial_ok && !ev_zero)
        |=> ##2 op_point_ff == ($past(addr_cnt_ff, 3)
                                 | $past(fuse_sense[CAL_BITS-1:0], 2)))
        else $error("trial value not applied from pulse count");

    a_perm_set: assert property (@(posedge clk_sys) disable iff (rst)
        (commit && !trial_ff && !ev_zero)
        |=> (vol_ff & $past(commit_mask)) == $past(commit_mask))
        else $error("addressed bitfield not set");
endmodule

// file: verilog/spp_pkg.sv
// package: constants and types for the supply pulse fuse programmer
package spp_pkg;
    // timing, figures in microseconds and the system clock rate
    localparam int CLK_MHZ            = 200;
    localparam int SYMBOL_PULSE_US    = 20;
    localparam int INTERPULSE_OFF_US  = 20;
    localparam int FUSE_PULSE_US      = 100;
    localparam int FUSE_PULSE_TYP_US  = 300;
    localparam int GROUP_IDLE_US      = 1000;
    localparam int SYMBOL_PULSE_CYC   = SYMBOL_PULSE_US * CLK_MHZ;
    localparam int INTERPULSE_OFF_CYC = INTERPULSE_OFF_US * CLK_MHZ;
    localparam int FUSE_PULSE_CYC     = FUSE_PULSE_US * CLK_MHZ;
    localparam int GROUP_IDLE_CYC     = GROUP_IDLE_US * CLK_MHZ;

    // bitfield layout
    localparam int NUM_FIELDS = 32;
    localparam int LOCK_ADDR  = 32;
    localparam int CAL_BITS   = 5;
    localparam int ADDR_W     = 6;

    // supply level codes from the comparator front end
    localparam logic [1:0] LVL_ZERO    = 2'h0;
    localparam logic [1:0] LVL_SUSTAIN = 2'h1;
    localparam logic [1:0] LVL_COUNT   = 2'h2;
    localparam logic [1:0] LVL_KEY     = 2'h3;

    // register map, byte addresses
    localparam int          APB_AW     = 12;
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_FIELDS = 12'h008;
    localparam logic [11:0] REG_ADDR   = 12'h00C;

    // register fields and reset values
    localparam int          CTRL_TRIAL_BIT = 0;
    localparam logic        CTRL_TRIAL_RST = 1'b0;
    localparam int          STAT_ABORT_BIT = 0;
    localparam int          STAT_LOCK_BIT  = 1;
    localparam int          STAT_STATE_LSB = 4;
    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

    typedef enum logic [1:0] {ST_IDLE, ST_KEY1, ST_KEY2, ST_ADDR} spp_state_t;
endpackage

// file: verilog/spp_sym_if.sv
// interface: decoded supply symbols from the pulse classifier
`timescale 1ns/1ps
interface spp_sym_if;
    logic pulse_count;
    logic pulse_key;
    logic pulse_fuse;
    logic pulse_bad;
    logic group_idle;
    logic supply_zero;

    modport src (
        output pulse_count,
        output pulse_key,
        output pulse_fuse,
        output pulse_bad,
        output group_idle,
        output supply_zero
    );
    modport dst (
        input pulse_count,
        input pulse_key,
        input pulse_fuse,
        input pulse_bad,
        input group_idle,
        input supply_zero
    );
endinterface

// file: verilog/spp_pulse_class.sv
// module: times supply level runs and turns them into symbols
`timescale 1ns/1ps
module spp_pulse_class #(
    parameter int SYM_CYC  = spp_pkg::SYMBOL_PULSE_CYC,
    parameter int OFF_CYC  = spp_pkg::INTERPULSE_OFF_CYC,
    parameter int FUSE_CYC = spp_pkg::FUSE_PULSE_CYC,
    parameter int IDLE_CYC = spp_pkg::GROUP_IDLE_CYC
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // quantised supply level
    input  wire logic [1:0] lvl_code,
    // decoded symbols
    spp_sym_if.src          sym
);
    import spp_pkg::*;

    localparam int CW = $clog2(IDLE_CYC + 1);

    logic [1:0]    prev_lvl_ff;
    logic [CW-1:0] run_cnt_ff;
    logic          fused_ff;
    logic          count_ff;
    logic          key_ff;
    logic          fuse_ff;
    logic          bad_ff;
    logic          idle_ff;
    logic          zero_ff;

    wire lvl_chg  = lvl_code != prev_lvl_ff;
    wire held_sym = run_cnt_ff >= CW'(SYM_CYC - 1);
    wire held_off = run_cnt_ff >= CW'(OFF_CYC - 1);
    wire to_pulse = lvl_code == LVL_COUNT || lvl_code == LVL_KEY;

    // run length, counts cycles minus one at the present level
    always_ff @(posedge clk_sys) begin
        if (rst || lvl_chg) begin
            run_cnt_ff <= '0;
        end else if (run_cnt_ff != CW'(IDLE_CYC)) begin
            run_cnt_ff <= run_cnt_ff + CW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_lvl_ff <= LVL_ZERO;
            fused_ff    <= 1'b0;
        end else begin
            prev_lvl_ff <= lvl_code;
            if (lvl_chg) begin
                fused_ff <= 1'b0;
            end else if (fuse_ff) begin
                fused_ff <= 1'b1;
            end
        end
    end

    // symbol pulses; a too short pulse or gap aborts rather than counts
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_ff <= 1'b0;
            key_ff   <= 1'b0;
            fuse_ff  <= 1'b0;
            bad_ff   <= 1'b0;
            idle_ff  <= 1'b0;
            zero_ff  <= 1'b0;
        end else begin
            count_ff <= lvl_chg && prev_lvl_ff == LVL_COUNT && held_sym;
            key_ff   <= lvl_chg && prev_lvl_ff == LVL_KEY && held_sym
                        && !fused_ff && !fuse_ff;
            fuse_ff  <= !lvl_chg && lvl_code == LVL_KEY && !fused_ff
                        && run_cnt_ff == CW'(FUSE_CYC - 1);
            bad_ff   <= lvl_chg && (
                        (prev_lvl_ff == LVL_COUNT && !held_sym)
                        || (prev_lvl_ff == LVL_KEY && !held_sym)
                        || (to_pulse && !(prev_lvl_ff == LVL_SUSTAIN
                                          && held_off)));
            idle_ff  <= !lvl_chg && lvl_code == LVL_SUSTAIN
                        && run_cnt_ff == CW'(IDLE_CYC - 1);
            zero_ff  <= lvl_code == LVL_ZERO;
        end
    end

    assign sym.pulse_count = count_ff;
    assign sym.pulse_key   = key_ff;
    assign sym.pulse_fuse  = fuse_ff;
    assign sym.pulse_bad   = bad_ff;
    assign sym.group_idle  = idle_ff;
    assign sym.supply_zero = zero_ff;

    a_count_width: assert property (@(posedge clk_sys) disable iff (rst)
        count_ff |-> $past(run_cnt_ff) >= CW'(SYM_CYC - 1))
        else $error("count symbol from a pulse shorter than symbol time");

    a_fuse_time: assert property (@(posedge clk_sys) disable iff (rst)
        fuse_ff |-> $past(run_cnt_ff) == CW'(FUSE_CYC - 1) && !key_ff)
        else $error("fuse symbol not at the fuse pulse time");
endmodule

// file: verif/spp_prog_model.sv
// partner model: external programmer coding levels on the supply pin
`timescale 1ns/1ps
module spp_prog_model #(
    parameter int PW        = 4010,
    parameter int SLOW      = 0,
    parameter int FUSE_HOLD = 4520,
    parameter int IDLE_HOLD = 5010
) (
    // clock
    input  wire logic       clk_sys,
    // coded supply level
    output logic [1:0]      lvl_code
);
    import spp_pkg::*;

    // never below sustain unless a clear is meant
    initial lvl_code = LVL_SUSTAIN;

    task automatic hold(input logic [1:0] lvl, input int n);
        lvl_code <= lvl;
        repeat (n) @(posedge clk_sys);
    endtask

    // one sequence; SLOW stretches the gaps before key and count pulses for a lazy programmer
    task automatic send_seq(input int n, input logic fuse);
        hold(LVL_SUSTAIN, PW + SLOW);
        hold(LVL_KEY, PW);
        hold(LVL_SUSTAIN, PW + SLOW);
        hold(LVL_COUNT, PW);
        hold(LVL_SUSTAIN, PW + SLOW);
        hold(LVL_KEY, PW);
        for (int i = 0; i < n; i++) begin
            hold(LVL_SUSTAIN, PW + SLOW);
            hold(LVL_COUNT, PW);
        end
        if (fuse) begin
            hold(LVL_SUSTAIN, PW);
            hold(LVL_KEY, FUSE_HOLD);
            hold(LVL_SUSTAIN, PW);
        end else begin
            hold(LVL_SUSTAIN, IDLE_HOLD);
        end
    endtask
endmodule

// file: verif/tb_top.sv
// testbench: programmer sequences and register checks
`timescale 1ns/1ps
module tb_top;
    import spp_pkg::*;
    localparam int FUSE_N = 4500;
    localparam int IDLE_N = 5000;
    localparam int PULSE_N = 4010;

    logic                  clk_sys;
    logic                  rst;
    logic [1:0]            lvl_code;
    logic [NUM_FIELDS-1:0] fuse_sense;
    logic                  fuse_blow;
    logic [ADDR_W-1:0]     fuse_addr;
    logic [ADDR_W-1:0]     last_fa;
    logic [CAL_BITS-1:0]   operate_switch_point;
    logic                  code_locked;
    logic [APB_AW-1:0]     paddr;
    logic                  psel, penable, pwrite, pready, pslverr, err;
    logic                  lock_blow;
    logic [31:0]           pwdata, prdata, rdata;
    int                    n_fail, n_tests, n_blow;

    spp_fuse_prog #(.FUSE_CYC(FUSE_N), .IDLE_CYC(IDLE_N)) u_spp_fuse_prog (
        .clk_sys              (clk_sys),
        .rst                  (rst),
        .lvl_code             (lvl_code),
        .fuse_sense           (fuse_sense),
        .fuse_blow            (fuse_blow),
        .fuse_addr            (fuse_addr),
        .operate_switch_point (operate_switch_point),
        .code_locked          (code_locked),
        .paddr                (paddr),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr)
    );

    spp_prog_model #(.PW(PULSE_N), .FUSE_HOLD(FUSE_N + 20),
                     .IDLE_HOLD(IDLE_N + 10))
        u_spp_prog_model (
        .clk_sys  (clk_sys),
        .lvl_code (lvl_code)
    );

    // fuse array: a blow pulse sets the sensed bit for good
    always @(posedge clk_sys) begin
        if (rst) begin
            fuse_sense <= '0;
            n_blow     <= 0;
        end else if (fuse_blow === 1'b1) begin
            n_blow <= n_blow + 1;
            last_fa <= fuse_addr;
            fuse_sense[fuse_addr - 1] <= 1'b1;
        end else if (lock_blow) begin
            fuse_sense[LOCK_ADDR - 1] <= 1'b1;
        end
    end

    task automatic check_word(input logic [31:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [APB_AW-1:0] a,
                       input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        // right after an edge pready still shows what that edge sampled;
        // only the watchdog ends a wait that never sees it
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd_chk(input logic [APB_AW-1:0] a, input logic [31:0] exp,
                          input logic exp_err);
        apb(1'b0, a, WORD_ZERO);
        check_word(rdata, exp, "read data");
        check_word({31'h0, err}, {31'h0, exp_err}, "slave error");
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // whole run needs about 94k cycles
    initial begin
        repeat (98000) @(posedge clk_sys);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = WORD_ZERO;
        lock_blow = 1'b0;
        n_fail = 0;
        n_tests = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        check_word({25'h0, fuse_blow, code_locked, operate_switch_point},
                   WORD_ZERO, "pins after reset");
        @(posedge clk_sys);
        rd_chk(REG_CTRL, WORD_ZERO, 1'b0);
        rd_chk(REG_STATUS, WORD_ZERO, 1'b0);
        rd_chk(REG_FIELDS, WORD_ZERO, 1'b0);
        rd_chk(12'h010, WORD_ZERO, 1'b1);
        apb(1'b1, REG_FIELDS, 32'hFFFF_FFFF);
        rd_chk(REG_FIELDS, WORD_ZERO, 1'b0);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        rd_chk(REG_CTRL, 32'h0000_0001, 1'b0);
        $display("test registers done");
        u_spp_prog_model.send_seq(2, 1'b0);
        rd_chk(REG_FIELDS, 32'h0000_0002, 1'b0);
        rd_chk(REG_ADDR, 32'h0000_0002, 1'b0);
        check_word({27'h0, operate_switch_point}, 32'h0000_0002, "trial");
        u_spp_prog_model.hold(LVL_ZERO, 20);
        u_spp_prog_model.hold(LVL_SUSTAIN, 10);
        rd_chk(REG_FIELDS, WORD_ZERO, 1'b0);
        check_word({27'h0, operate_switch_point}, WORD_ZERO,
                   "cleared");
        $display("test trial done");
        apb(1'b1, REG_CTRL, WORD_ZERO);
        // only the one-bit at address 1 is fused
        u_spp_prog_model.send_seq(1, 1'b1);
        check_word(n_blow, 32'h0000_0001, "blow count");
        check_word({26'h0, last_fa}, 32'h0000_0001, "blow addr");
        rd_chk(REG_FIELDS, 32'h0000_0001, 1'b0);
        u_spp_prog_model.hold(LVL_ZERO, 20);
        u_spp_prog_model.hold(LVL_SUSTAIN, 10);
        rd_chk(REG_FIELDS, 32'h0000_0001, 1'b0);
        check_word({27'h0, operate_switch_point}, 32'h0000_0001,
                   "fused");
        $display("test fuse done");
        // lock fuse goes last, after the value is fused
        lock_blow <= 1'b1;
        repeat (5) @(posedge clk_sys);
        check_word({31'h0, code_locked}, 32'h0000_0001,
                   "locked");
        rd_chk(REG_STATUS, 32'h0000_0002, 1'b0);
        rd_chk(REG_FIELDS, 32'h8000_0001, 1'b0);
        // a valid key would leave idle if coding were still open
        u_spp_prog_model.hold(LVL_KEY, PULSE_N);
        u_spp_prog_model.hold(LVL_SUSTAIN, 10);
        rd_chk(REG_STATUS, 32'h0000_0002, 1'b0);
        $display("test lock done");
        final_report();
    end
endmodule
